/* hdl/apd_acquire.sv */
// encoder acquisition engine: fetches rotation count and initial pulses
`timescale 1ns/1ps
module apd_acquire #(
  parameter int TURN_W = 16,
  parameter int PULSE_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic busy,
  output logic done,
  output logic [TURN_W-1:0] turns,
  output logic [PULSE_W-1:0] init_pulses,
  output logic enc_req,
  input wire logic enc_ack,
  input wire logic [TURN_W-1:0] enc_turns,
  input wire logic [PULSE_W-1:0] enc_pulses
);
  import apd_pkg::*;

  typedef struct packed {
    apd_acq_state_t st;
    logic done;
    logic [TURN_W-1:0] turns;
    logic [PULSE_W-1:0] pulses;
  } apd_acq_t;

  apd_acq_t s_q;
  apd_acq_t s_d;

  // =========================================
  // sequencing
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      APD_ACQ_IDLE: begin
        if (start) begin
          s_d.st = APD_ACQ_WAIT;
        end
      end
      APD_ACQ_WAIT: begin
        // battery-kept values are taken as the encoder holds them now
        if (enc_ack) begin
          s_d.turns = enc_turns;
          s_d.pulses = enc_pulses;
          s_d.done = 1'b1;
          s_d.st = APD_ACQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.st == APD_ACQ_WAIT);
  assign enc_req = (s_q.st == APD_ACQ_WAIT);
  assign done = s_q.done;
  assign turns = s_q.turns;
  assign init_pulses = s_q.pulses;

endmodule

/* hdl/apd_cfg.svh */
// register offsets, field positions and reset values of the position block
`ifndef APD_CFG_SVH
`define APD_CFG_SVH

`define APD_OFS_CTRL_WORD 8'h00
`define APD_OFS_COMMAND 8'h04
`define APD_OFS_STATUS 8'h08
`define APD_OFS_PPR 8'h0C
`define APD_OFS_TURNS 8'h10
`define APD_OFS_INIT_PULSES 8'h14
`define APD_OFS_ABS_POS 8'h18
`define APD_OFS_FB_POS 8'h1C
`define APD_OFS_MON1 8'h20
`define APD_OFS_MON2 8'h24
`define APD_OFS_MON3 8'h28

`define APD_MON1_LSB 16
`define APD_MON2_LSB 20
`define APD_MON3_LSB 24
`define APD_MON_W 4
`define APD_RSVD_MASK 32'hF000_0000
`define APD_CTRL_WORD_RST 32'h0000_0000
`define APD_PPR_RST 24'h000400

`define APD_CMD_INIT_BIT 0
`define APD_CMD_ERST_BIT 1
`define APD_STAT_VALID_BIT 0
`define APD_STAT_BUSY_BIT 1

`define APD_RESP_OKAY 2'h0
`define APD_RESP_SLVERR 2'h2

`endif

/* hdl/apd_pkg.sv */
// types shared by the position block and its acquisition engine
package apd_pkg;

  typedef enum logic [0:0] {
    APD_ACQ_IDLE = 1'b0,
    APD_ACQ_WAIT = 1'b1
  } apd_acq_state_t;

  typedef enum logic [3:0] {
    APD_MON_ABS_POS = 4'h0,
    APD_MON_FB_POS = 4'h1,
    APD_MON_TURNS = 4'h2,
    APD_MON_INIT_PULSES = 4'h3
  } apd_mon_sel_t;

  typedef logic [1:0] apd_resp_t;

endpackage

/* hdl/apd_top.sv */
// absolute position detection block with an AXI4-Lite register slave
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "apd_cfg.svh"
module apd_top #(
  parameter int ADDR_W = 8,
  parameter int TURN_W = 16,
  parameter int PULSE_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output apd_pkg::apd_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output apd_pkg::apd_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic enc_req,
  input wire logic enc_ack,
  input wire logic [TURN_W-1:0] enc_turns,
  input wire logic [PULSE_W-1:0] enc_pulses,
  output logic enc_clear,
  input wire logic inc_step,
  input wire logic inc_dir,
  output logic [3:0] monitor_select_first,
  output logic [3:0] monitor_select_second,
  output logic [3:0] monitor_select_third,
  output logic position_valid,
  output logic [31:0] absolute_position,
  output logic [31:0] feedback_coordinate_position
);
  import apd_pkg::*;

  // =========================================
  // parameter checks
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 6 and 32");
  end
  if (TURN_W < 1 || TURN_W > 32 || PULSE_W < 1 || PULSE_W > 32) begin : g_bad_w
    $error("TURN_W and PULSE_W must lie between 1 and 32");
  end

  typedef struct packed {
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    apd_resp_t bresp;
    logic rvalid;
    logic [31:0] rdata;
    apd_resp_t rresp;
    logic [31:0] ctrl_word;
    logic [PULSE_W-1:0] ppr;
    logic acq_start;
    logic enc_clear;
    logic valid;
    logic [TURN_W-1:0] turns;
    logic [PULSE_W-1:0] po;
    logic [31:0] moved;
    logic [31:0] abs_pos;
    logic [31:0] fb_pos;
  } apd_state_t;

  apd_state_t s_q;
  apd_state_t s_d;

  logic acq_busy;
  logic acq_done;
  logic [TURN_W-1:0] acq_turns;
  logic [PULSE_W-1:0] acq_po;

  // =========================================
  // functions
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    addr_mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] <= (ADDR_W-2)'(10))
      && (o <= `APD_OFS_MON3);
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    merge_strb = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_strb[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  function automatic logic [31:0] mon_value(input logic [3:0] sel,
      input apd_state_t s);
    mon_value = 32'h0000_0000;
    if (s.valid) begin
      unique case (sel)
        APD_MON_ABS_POS: mon_value = s.abs_pos;
        APD_MON_FB_POS: mon_value = s.fb_pos;
        APD_MON_TURNS: mon_value = 32'(signed'(s.turns));
        APD_MON_INIT_PULSES: mon_value = 32'(s.po);
        default: mon_value = 32'h0000_0000;
      endcase
    end
  endfunction

  function automatic logic [3:0] mon_field(input logic [31:0] w,
      input int idx);
    unique case (idx)
      0: mon_field = w[`APD_MON1_LSB +: `APD_MON_W];
      1: mon_field = w[`APD_MON2_LSB +: `APD_MON_W];
      default: mon_field = w[`APD_MON3_LSB +: `APD_MON_W];
    endcase
  endfunction

  // =========================================
  // acquisition engine
  apd_acquire #(
    .TURN_W(TURN_W),
    .PULSE_W(PULSE_W)
  ) u_acquire (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(s_q.acq_start),
    .busy(acq_busy),
    .done(acq_done),
    .turns(acq_turns),
    .init_pulses(acq_po),
    .enc_req(enc_req),
    .enc_ack(enc_ack),
    .enc_turns(enc_turns),
    .enc_pulses(enc_pulses)
  );

  // =========================================
  // next state
  logic aw_now;
  logic w_now;
  logic do_write;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [7:0] wo;
  logic [7:0] ro;
  logic [63:0] prod;
  logic [31:0] mons [3];
  logic init_wr;
  logic eng_busy;

  always_comb begin
    s_d = s_q;
    s_d.acq_start = 1'b0;
    s_d.enc_clear = 1'b0;
    init_wr = 1'b0;
    // a pending start or a finishing capture still counts as busy
    eng_busy = acq_busy || s_q.acq_start || acq_done;
    for (int i = 0; i < 3; i++) begin
      mons[i] = mon_value(mon_field(s_q.ctrl_word, i), s_q);
    end

    // write channel: address and data in either order
    aw_now = s_q.aw_have || (s_axi_awvalid && s_axi_awready);
    w_now = s_q.w_have || (s_axi_wvalid && s_axi_wready);
    wa = s_q.aw_have ? s_q.aw_addr : s_axi_awaddr;
    wd = s_q.w_have ? s_q.w_data : s_axi_wdata;
    ws = s_q.w_have ? s_q.w_strb : s_axi_wstrb;
    wo = wa[7:0];
    do_write = aw_now && w_now && !s_q.bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_write) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `APD_RESP_OKAY;
      if (!addr_mapped(wa)) begin
        s_d.bresp = `APD_RESP_SLVERR;
      end else if (wo == `APD_OFS_CTRL_WORD) begin
        // reserved bits are kept at zero whatever is written
        s_d.ctrl_word = merge_strb(s_q.ctrl_word, wd, ws)
          & ~`APD_RSVD_MASK;
      end else if (wo == `APD_OFS_PPR) begin
        s_d.ppr = PULSE_W'(merge_strb(32'(s_q.ppr), wd, ws));
      end else if (wo == `APD_OFS_COMMAND && ws[0]) begin
        if (wd[`APD_CMD_INIT_BIT] && !eng_busy) begin
          init_wr = 1'b1;
        end
        if (wd[`APD_CMD_ERST_BIT] && !eng_busy) begin
          s_d.turns = '0;
          s_d.enc_clear = 1'b1;
        end
      end
    end

    // read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ro = s_axi_araddr[7:0];
      s_d.rvalid = 1'b1;
      s_d.rresp = `APD_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (!addr_mapped(s_axi_araddr)) begin
        s_d.rresp = `APD_RESP_SLVERR;
      end else begin
        unique case (ro)
          `APD_OFS_CTRL_WORD: s_d.rdata = s_q.ctrl_word;
          `APD_OFS_STATUS: begin
            s_d.rdata[`APD_STAT_VALID_BIT] = s_q.valid;
            s_d.rdata[`APD_STAT_BUSY_BIT] = eng_busy;
          end
          `APD_OFS_PPR: s_d.rdata = 32'(s_q.ppr);
          `APD_OFS_TURNS,
          `APD_OFS_INIT_PULSES,
          `APD_OFS_ABS_POS,
          `APD_OFS_FB_POS: begin
            if (s_q.valid) begin
              unique case (ro)
                `APD_OFS_TURNS: s_d.rdata = 32'(signed'(s_q.turns));
                `APD_OFS_INIT_PULSES: s_d.rdata = 32'(s_q.po);
                `APD_OFS_ABS_POS: s_d.rdata = s_q.abs_pos;
                default: s_d.rdata = s_q.fb_pos;
              endcase
            end
          end
          `APD_OFS_MON1: s_d.rdata = mons[0];
          `APD_OFS_MON2: s_d.rdata = mons[1];
          `APD_OFS_MON3: s_d.rdata = mons[2];
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end else begin
      ro = 8'h00;
    end

    // sensor initialisation: data marked invalid until capture ends
    if (init_wr) begin
      s_d.acq_start = 1'b1;
      s_d.valid = 1'b0;
    end
    if (acq_done) begin
      s_d.turns = acq_turns;
      s_d.po = acq_po;
      s_d.moved = 32'h0000_0000;
      s_d.valid = 1'b1;
    end else if (inc_step) begin
      s_d.moved = inc_dir ? s_q.moved - 32'h0000_0001
                          : s_q.moved + 32'h0000_0001;
    end

    // position arithmetic
    prod = 64'(signed'(s_q.turns)) * 64'(s_q.ppr);
    s_d.abs_pos = prod[31:0] + 32'(s_q.po);
    s_d.fb_pos = s_q.abs_pos + s_q.moved;
  end

  // =========================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl_word <= `APD_CTRL_WORD_RST;
      s_q.ppr <= PULSE_W'(`APD_PPR_RST);
    end else begin
      s_q <= s_d;
    end
  end

  // =========================================
  // outputs
  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign enc_clear = s_q.enc_clear;
  assign monitor_select_first = mon_field(s_q.ctrl_word, 0);
  assign monitor_select_second = mon_field(s_q.ctrl_word, 1);
  assign monitor_select_third = mon_field(s_q.ctrl_word, 2);
  assign position_valid = s_q.valid;
  assign absolute_position = s_q.valid ? s_q.abs_pos : 32'h0000_0000;
  assign feedback_coordinate_position =
    s_q.valid ? s_q.fb_pos : 32'h0000_0000;

endmodule

/* testbench/apd_checker_assertions.sv */
// port checker of the absolute position block
`timescale 1ns/1ps
module apd_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire apd_pkg::apd_resp_t s_axi_bresp,
  input wire logic enc_req,
  input wire logic enc_ack,
  input wire logic enc_clear,
  input wire logic inc_step,
  input wire logic position_valid,
  input wire logic [31:0] absolute_position,
  input wire logic [31:0] feedback_coordinate_position
);
  import apd_pkg::*;
  // ==========================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ack_s;
    enc_req && enc_ack;
  endsequence
  sequence quiet_s;
    (position_valid && !inc_step && !enc_clear && !s_axi_bvalid) [*5];
  endsequence
  a_invalid_zero: assert property (
    !position_valid [*2] |-> absolute_position == 32'h0 &&
      feedback_coordinate_position == 32'h0)
    else $error("position shown while invalid");
  a_busy_invalid: assert property (
    enc_req |-> !position_valid)
    else $error("valid during acquisition");
  a_req_hold: assert property (
    enc_req && !enc_ack |=> enc_req)
    else $error("encoder request dropped early");
  a_req_drop: assert property (
    ack_s |=> !enc_req)
    else $error("encoder request kept after ack");
  a_valid_ack: assert property (
    ack_s |-> ##2 position_valid)
    else $error("valid late after ack");
  a_clear_pulse: assert property (
    enc_clear |=> !enc_clear)
    else $error("encoder clear longer than a cycle");
  a_clear_idle: assert property (
    enc_clear |-> !enc_req)
    else $error("encoder clear during acquisition");
  a_fb_still: assert property (
    quiet_s |-> $stable(feedback_coordinate_position))
    else $error("feedback moved without a step");
  a_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule

bind apd_top apd_checker u_apd_checker (.*);

/* testbench/apd_enc_model.sv */
// encoder model: answers acquisition requests, tracks shaft turns
`timescale 1ns/1ps
module apd_enc_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enc_req,
  input wire logic enc_clear,
  input wire logic [15:0] shaft_turns,
  input wire logic [23:0] shaft_pulses,
  output logic enc_ack,
  output logic [15:0] enc_turns,
  output logic [23:0] enc_pulses
);
  logic [15:0] base = 16'h0;
  int wait_n = 0;
  initial begin
    enc_ack = 1'b0;
    enc_turns = 16'h0;
    enc_pulses = 24'h0;
  end
  // ==========================================================
  // answer; base is battery backed, so no reset clears it
  always @(posedge aclk) begin
    enc_ack <= 1'b0;
    enc_turns <= ~enc_turns;
    enc_pulses <= ~enc_pulses;
    if (enc_clear) base <= shaft_turns;
    if (!aresetn) wait_n <= 0;
    else if (enc_req && !enc_ack) begin
      if (wait_n == 0) begin
        enc_ack <= 1'b1;
        enc_turns <= shaft_turns - base;
        enc_pulses <= shaft_pulses;
        wait_n <= $urandom_range(6);
      end else wait_n <= wait_n - 1;
    end
  end
endmodule

/* testbench/tb_apd_top.sv */
// self-checking bench of the absolute position block
`timescale 1ns/1ps
`include "apd_cfg.svh"
module tb_apd_top;
  import apd_pkg::*;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, absolute_position;
  logic [31:0] feedback_coordinate_position, ppr, r, ctl;
  logic [3:0] s_axi_wstrb, monitor_select_first, monitor_select_second;
  logic [3:0] monitor_select_third;
  apd_resp_t s_axi_bresp, s_axi_rresp, rs;
  logic enc_req, enc_ack, enc_clear, inc_step, inc_dir, position_valid;
  logic [15:0] enc_turns, shaft_turns, base_t, et;
  logic [23:0] enc_pulses, shaft_pulses, epo;
  logic [1:0] s;
  logic [31:0] org, pair_enc, pair_pls;
  // axis wraps every 65536 pulses; host gear ratio of 3
  localparam logic [31:0] WRAP_M = 32'h0000_FFFF;
  localparam logic [31:0] GEAR = 32'h0000_0003;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int moved = 0;
  apd_top u_apd_top (.*);
  apd_enc_model u_apd_enc_model (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================
  // tasks
  task close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit got;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        got = 1;
      end
    end
  endtask
  task rd(input logic [7:0] a);
    bit got;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        r = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        got = 1;
      end
    end
  endtask
  function automatic logic [31:0] sx(input logic [15:0] t);
    return {{16{t[15]}}, t};
  endfunction
  function automatic logic [31:0] eabs();
    return sx(et) * ppr + {8'h00, epo};
  endfunction
  function automatic logic [31:0] mon(input int k);
    case (k)
      0: return eabs();
      1: return eabs() + 32'(moved);
      2: return sx(et);
      3: return {8'h00, epo};
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] mach(input logic [31:0] p);
    return (p * GEAR + org) & WRAP_M;
  endfunction
  task check_pos();
    rd(`APD_OFS_TURNS);
    chk("turns", sx(et), r);
    rd(`APD_OFS_INIT_PULSES);
    chk("pulses", {8'h00, epo}, r);
    rd(`APD_OFS_ABS_POS);
    chk("abs", eabs(), r);
    chk("abs_port", eabs(), absolute_position);
    rd(`APD_OFS_FB_POS);
    chk("fb", mon(1), r);
    chk("fb_port", mon(1), feedback_coordinate_position);
  endtask
  task do_init();
    wr(`APD_OFS_COMMAND, 32'h1);
    et = shaft_turns - base_t;
    epo = shaft_pulses;
    moved = 0;
    r = 32'h0;
    for (int i = 0; i < 40 && r[0] !== 1'b1; i++) rd(`APD_OFS_STATUS);
    chk("status", 32'h1, r);
    repeat (3) @(posedge aclk);
    chk("valid", 32'h1, {31'h0, position_valid});
  endtask
  // ==========================================================
  // sequence
  initial begin
    void'($urandom(74077));
    org = $urandom;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, inc_step, inc_dir} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, shaft_turns} = '0;
    {shaft_pulses, base_t} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`APD_OFS_CTRL_WORD);
    chk("ctrl_rst", 32'h0, r);
    rd(`APD_OFS_PPR);
    chk("ppr_rst", 32'h400, r);
    rd(`APD_OFS_ABS_POS);
    chk("abs_invalid", 32'h0, r);
    rd(8'h30);
    chk("rd_unmapped", 32'h2, {30'h0, rs});
    chk("rd_unmapped_data", 32'h0, r);
    wr(8'h30, 32'h1);
    chk("wr_unmapped", 32'h2, rs);
    wr(`APD_OFS_STATUS, 32'hFFFF_FFFF);
    rd(`APD_OFS_STATUS);
    chk("status_ro", 32'h0, r);
    repeat (4) begin
      ctl = $urandom & 32'h0FFF_FFFF;
      wr(`APD_OFS_CTRL_WORD, ctl);
      rd(`APD_OFS_CTRL_WORD);
      chk("ctrl", ctl, r);
      chk("sel_mon", ctl[27:16], {monitor_select_third,
        monitor_select_second, monitor_select_first});
    end
    s_axi_wstrb <= 4'h4;
    wr(`APD_OFS_CTRL_WORD, 32'h00FF_0000);
    s_axi_wstrb <= 4'hF;
    rd(`APD_OFS_CTRL_WORD);
    chk("ctrl_strb", {ctl[31:24], 8'hFF, ctl[15:0]}, r);
    ppr = ($urandom & 32'h00FF_FFFF) | 32'h1;
    wr(`APD_OFS_PPR, ppr);
    shaft_turns <= 16'($urandom);
    shaft_pulses <= 24'($urandom);
    do_init();
    check_pos();
    for (int k = 0; k < 5; k++) begin
      ctl = (k << 16) | (((k + 1) % 5) << 20) | (((k + 2) % 5) << 24);
      wr(`APD_OFS_CTRL_WORD, ctl);
      for (int j = 0; j < 3; j++) begin
        rd(`APD_OFS_MON1 + 8'(4 * j));
        chk("monitor", mon((k + j) % 5), r);
      end
    end
    repeat (40) begin
      @(posedge aclk);
      s = 2'($urandom);
      inc_step <= s[0];
      inc_dir <= s[1];
      if (s[0]) moved += s[1] ? -1 : 1;
    end
    @(posedge aclk);
    inc_step <= 1'b0;
    repeat (4) @(posedge aclk);
    check_pos();
    wr(`APD_OFS_COMMAND, 32'h2);
    base_t = shaft_turns;
    et = 16'h0;
    repeat (6) @(posedge aclk);
    check_pos();
    pair_enc = r;
    pair_pls = mach(r);
    shaft_turns <= shaft_turns + 16'h0005;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ppr = 32'h400;
    rd(`APD_OFS_STATUS);
    chk("status_reset", 32'h0, r);
    do_init();
    check_pos();
    pair_pls = (pair_pls + (r - pair_enc) * GEAR) & WRAP_M;
    chk("pulse_pos", mach(mon(1)), pair_pls);
    close_out();
  end
endmodule
